/* File: hw/flash_security_status_and_dummy_config.sv */
// Security flag register and dummy-count configuration of the serial flash.
// Assumes the engine pulses on ref_clk, and commands arrive on the link clock.
//
// Functional notes
// - The two-bit dummy select gives 8 for 11, 6 for 10, 8 for 01 and 10 for 00 (default).
// - A failed or protected erase sets the erase-fail flag.
// - A following successful erase clears the erase-fail flag.
// - Failure flags only record status and never stop an operation.
// - A failed or protected program sets the program-fail flag.
// - A following successful program clears the program-fail flag.
// - An erase suspended by command sets the erase-suspended flag.
// - Resuming the suspended erase clears the erase-suspended flag.
// - A program suspended by command sets the program-suspended flag.
// - Resuming the suspended program clears the program-suspended flag.
// - Bit 0 reports whether the secured OTP area was factory locked.
// - The write security command sets the customer lock, stored non-volatile.
// - Once locked, the lock bit and the secured OTP area can no longer change.
// - While secured OTP mode is active the main array is refused.
// - Bit 7 holds the one-time protection mode select, 0 normal, 1 individual.
`timescale 1ns/10ps
module flash_security_status_and_dummy_config
  import flash_sec_pkg::*;
(
  // System clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Link clock and commands from the command decoder
  input wire logic linkClk,
  input wire logic writeSecurityCmd,
  input wire logic protectModeCmd,
  input wire logic dummyWriteCmd,
  input wire logic [flash_sec_pkg::DC_WIDTH-1:0] dummyWriteData,
  // Program/erase engine events
  input wire logic eraseOk,
  input wire logic eraseBad,
  input wire logic programOk,
  input wire logic programBad,
  input wire logic eraseSuspended,
  input wire logic eraseResumed,
  input wire logic programSuspended,
  input wire logic programResumed,
  input wire logic otpModeActive,
  // Non-volatile state loaded after reset
  input wire logic nvCustLock,
  input wire logic nvProtMode,
  input wire logic factoryLockPin,
  // Status and control outputs
  output logic [flash_sec_pkg::SEC_WIDTH-1:0] securityFlags,
  output logic [flash_sec_pkg::DC_WIDTH-1:0] dummy_count_select,
  output logic [flash_sec_pkg::DUMMY_WIDTH-1:0] dummyClocks,
  output logic mainArrayBlock,
  output logic otpWriteAllow,
  output logic nvLockProgram,
  output logic nvProtProgram
);
  import flash_sec_pkg::*;

  // ==========================================================================
  // Elaboration checks on the package layout
  if (SEC_WIDTH != $bits(SEC_RESET)) begin : g_badSecWidth
    $error("security image width differs from its reset value");
  end
  if (DC_WIDTH != $bits(DC_RESET)) begin : g_badDcWidth
    $error("dummy select width differs from its reset value");
  end
  if (DUMMY_WIDTH != $bits(DUMMY_DC0)) begin : g_badDummyWidth
    $error("dummy count width differs from the decoded counts");
  end
  if (SYNC_STAGES != 32'h2) begin : g_badSyncStages
    $error("the crossing is built for two synchroniser stages");
  end
  if ((BIT_FACTORY_LOCK >= SEC_WIDTH) || (BIT_CUST_LOCK >= SEC_WIDTH) ||
      (BIT_PROG_SUSP >= SEC_WIDTH) || (BIT_ERASE_SUSP >= SEC_WIDTH)) begin : g_badLowBits
    $error("a low flag position lies outside the image");
  end
  if ((BIT_RESERVED >= SEC_WIDTH) || (BIT_PROG_FAIL >= SEC_WIDTH) ||
      (BIT_ERASE_FAIL >= SEC_WIDTH) || (BIT_PROT_MODE >= SEC_WIDTH)) begin : g_badHighBits
    $error("a high flag position lies outside the image");
  end
  if ((DUMMY_DC0 == 4'h0) || (DUMMY_DC1 == 4'h0) || (DUMMY_DC2 == 4'h0) ||
      (DUMMY_DC3 == 4'h0)) begin : g_badDummyCount
    $error("every dummy count must be at least one clock");
  end
  if (SEC_RESET[BIT_RESERVED] != 1'b0) begin : g_badReserved
    $error("the reserved bit must reset to zero");
  end

  // ==========================================================================
  // Reset release in both domains
  logic [1:0] rstPipe_q;
  logic rstN;
  logic [1:0] linkRstPipe_q;
  logic linkRstN;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstN = rstPipe_q[1];

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      linkRstPipe_q <= 2'h0;
    end else begin
      linkRstPipe_q <= {linkRstPipe_q[0], 1'b1};
    end
  end
  assign linkRstN = linkRstPipe_q[1];

  // ==========================================================================
  // Link domain: commands become toggles, dummy data held with its toggle
  logic lockTgl_q;
  logic protTgl_q;
  logic dcTgl_q;
  logic [DC_WIDTH-1:0] dcHold_q;

  always_ff @(posedge linkClk or negedge linkRstN) begin
    if (!linkRstN) begin
      lockTgl_q <= 1'b0;
    end else if (writeSecurityCmd) begin
      lockTgl_q <= ~lockTgl_q;
    end
  end

  always_ff @(posedge linkClk or negedge linkRstN) begin
    if (!linkRstN) begin
      protTgl_q <= 1'b0;
    end else if (protectModeCmd) begin
      protTgl_q <= ~protTgl_q;
    end
  end

  always_ff @(posedge linkClk or negedge linkRstN) begin
    if (!linkRstN) begin
      dcTgl_q <= 1'b0;
      dcHold_q <= DC_RESET;
    end else if (dummyWriteCmd) begin
      dcTgl_q <= ~dcTgl_q;
      dcHold_q <= dummyWriteData;
    end
  end

  // ==========================================================================
  // Crossing into the system domain
  logic [3:0] syncOut;
  logic lockTglS_q;
  logic protTglS_q;
  logic dcTglS_q;
  logic lockReq;
  logic protReq;
  logic dcReq;
  logic factoryLockS;

  bit_sync #(.WIDTH(4)) u_sync (
    .clk(ref_clk),
    .rstN(rstN),
    .din({factoryLockPin, dcTgl_q, protTgl_q, lockTgl_q}),
    .dout(syncOut)
  );
  assign factoryLockS = syncOut[3];

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      lockTglS_q <= 1'b0;
      protTglS_q <= 1'b0;
      dcTglS_q <= 1'b0;
    end else if (clkEn) begin
      lockTglS_q <= syncOut[0];
      protTglS_q <= syncOut[1];
      dcTglS_q <= syncOut[2];
    end
  end
  function automatic logic tglChanged(input logic synced, input logic seen);
    return synced ^ seen;
  endfunction

  assign lockReq = tglChanged(syncOut[0], lockTglS_q);
  assign protReq = tglChanged(syncOut[1], protTglS_q);
  assign dcReq = tglChanged(syncOut[2], dcTglS_q);

  // ==========================================================================
  // Non-volatile bits: loaded once after reset release, then one-time set
  logic loaded_q;
  logic custLock_q;
  logic protMode_q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      loaded_q <= 1'b0;
    end else if (clkEn) begin
      loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      custLock_q <= 1'b0;
    end else if (clkEn) begin
      if (!loaded_q) begin
        custLock_q <= nvCustLock;
      end else if (lockReq && !custLock_q) begin
        custLock_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      nvLockProgram <= 1'b0;
    end else if (clkEn) begin
      nvLockProgram <= loaded_q && lockReq && !custLock_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      protMode_q <= 1'b0;
    end else if (clkEn) begin
      if (!loaded_q) begin
        protMode_q <= nvProtMode;
      end else if (protReq && !protMode_q) begin
        protMode_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      nvProtProgram <= 1'b0;
    end else if (clkEn) begin
      nvProtProgram <= loaded_q && protReq && !protMode_q;
    end
  end

  // ==========================================================================
  // Volatile flags: set wins over clear in the same cycle
  logic eraseFail_q;
  logic programFail_q;
  logic eraseSusp_q;
  logic programSusp_q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      eraseFail_q <= 1'b0;
    end else if (clkEn) begin
      if (eraseBad) begin
        eraseFail_q <= 1'b1;
      end else if (eraseOk) begin
        eraseFail_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      programFail_q <= 1'b0;
    end else if (clkEn) begin
      if (programBad) begin
        programFail_q <= 1'b1;
      end else if (programOk) begin
        programFail_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      eraseSusp_q <= 1'b0;
    end else if (clkEn) begin
      if (eraseSuspended) begin
        eraseSusp_q <= 1'b1;
      end else if (eraseResumed) begin
        eraseSusp_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      programSusp_q <= 1'b0;
    end else if (clkEn) begin
      if (programSuspended) begin
        programSusp_q <= 1'b1;
      end else if (programResumed) begin
        programSusp_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Dummy select and decode
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      dummy_count_select <= DC_RESET;
    end else if (clkEn && dcReq) begin
      dummy_count_select <= dcHold_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      dummyClocks <= dummyCount(DC_RESET);
    end else if (clkEn) begin
      dummyClocks <= dummyCount(dummy_count_select);
    end
  end

  // ==========================================================================
  // Register image and access gates
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      securityFlags <= SEC_RESET;
    end else if (clkEn) begin
      securityFlags[BIT_PROT_MODE] <= protMode_q;
      securityFlags[BIT_ERASE_FAIL] <= eraseFail_q;
      securityFlags[BIT_PROG_FAIL] <= programFail_q;
      securityFlags[BIT_RESERVED] <= 1'b0;
      securityFlags[BIT_ERASE_SUSP] <= eraseSusp_q;
      securityFlags[BIT_PROG_SUSP] <= programSusp_q;
      securityFlags[BIT_CUST_LOCK] <= custLock_q;
      securityFlags[BIT_FACTORY_LOCK] <= factoryLockS;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      mainArrayBlock <= 1'b0;
    end else if (clkEn) begin
      mainArrayBlock <= otpModeActive;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      otpWriteAllow <= 1'b0;
    end else if (clkEn) begin
      otpWriteAllow <= loaded_q && !custLock_q;
    end
  end

endmodule

/* File: hw/flash_sec_pkg.sv */
// Constants, field layout and dummy-count decode for the security flag block.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_sec_pkg;

  // ==========================================================================
  // Register layout
  localparam int SEC_WIDTH = 8;
  localparam int BIT_FACTORY_LOCK = 0;
  localparam int BIT_CUST_LOCK = 1;
  localparam int BIT_PROG_SUSP = 2;
  localparam int BIT_ERASE_SUSP = 3;
  localparam int BIT_RESERVED = 4;
  localparam int BIT_PROG_FAIL = 5;
  localparam int BIT_ERASE_FAIL = 6;
  localparam int BIT_PROT_MODE = 7;
  localparam logic [7:0] SEC_RESET = 8'h00;

  // ==========================================================================
  // Dummy-count select
  localparam int DC_WIDTH = 2;
  localparam int DUMMY_WIDTH = 4;
  localparam logic [1:0] DC_RESET = 2'h0;
  localparam logic [3:0] DUMMY_DC3 = 4'h8;
  localparam logic [3:0] DUMMY_DC2 = 4'h6;
  localparam logic [3:0] DUMMY_DC1 = 4'h8;
  localparam logic [3:0] DUMMY_DC0 = 4'hA;

  // ==========================================================================
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  function automatic logic [3:0] dummyCount(input logic [1:0] sel);
    logic [3:0] n;
    n = DUMMY_DC0;
    case (sel)
      2'h3: n = DUMMY_DC3;
      2'h2: n = DUMMY_DC2;
      2'h1: n = DUMMY_DC1;
      default: n = DUMMY_DC0;
    endcase
    return n;
  endfunction

endpackage

/* File: hw/bit_sync.sv */
// Two-flop level synchroniser, one per bit.
// Assumes asynchronous active-low reset in the destination domain.
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_badWidth
    $error("bit_sync width must be positive");
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* File: sim/flash_sec_props.sv */
// Port assertions for the security flag block.
// Assumes it is bound to the block's top module.
`timescale 1ns/10ps
module flash_sec_props
  import flash_sec_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Engine events
  input wire logic eraseOk,
  input wire logic eraseBad,
  input wire logic programBad,
  input wire logic eraseSuspended,
  input wire logic otpModeActive,
  // Outputs
  input wire logic [flash_sec_pkg::SEC_WIDTH-1:0] securityFlags,
  input wire logic [flash_sec_pkg::DC_WIDTH-1:0] dummy_count_select,
  input wire logic [flash_sec_pkg::DUMMY_WIDTH-1:0] dummyClocks,
  input wire logic mainArrayBlock,
  input wire logic otpWriteAllow,
  input wire logic nvLockProgram
);
  // ==========
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_efS; clkEn && eraseBad ##1 clkEn |=> securityFlags[6]; endproperty
  a_efS: assert property (p_efS) else $error("erase fail not set");
  property p_efC; clkEn && eraseOk && !eraseBad ##1 clkEn |=> !securityFlags[6]; endproperty
  a_efC: assert property (p_efC) else $error("erase fail not cleared");
  property p_pfS; clkEn && programBad ##1 clkEn |=> securityFlags[5]; endproperty
  a_pfS: assert property (p_pfS) else $error("program fail not set");
  property p_esS; clkEn && eraseSuspended ##1 clkEn |=> securityFlags[3]; endproperty
  a_esS: assert property (p_esS) else $error("erase suspend not set");
  property p_lkP; nvLockProgram && clkEn |=> securityFlags[1] && !nvLockProgram; endproperty
  a_lkP: assert property (p_lkP) else $error("lock store wrong");
  property p_lkS; securityFlags[1] |=> securityFlags[1] && !otpWriteAllow && !nvLockProgram;
  endproperty
  a_lkS: assert property (p_lkS) else $error("lock changed");
  property p_otp; clkEn |=> mainArrayBlock == $past(otpModeActive); endproperty
  a_otp: assert property (p_otp) else $error("array block wrong");
  property p_rsv; !securityFlags[4]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_dc; clkEn |=> dummyClocks == (($past(dummy_count_select) == 2'h2) ? 4'h6 :
    ($past(dummy_count_select) == 2'h0) ? 4'hA : 4'h8); endproperty
  a_dc: assert property (p_dc) else $error("dummy count wrong");
endmodule
bind flash_security_status_and_dummy_config flash_sec_props i_props (.ref_clk, .rst_b,
  .clkEn, .eraseOk, .eraseBad, .programBad, .eraseSuspended, .otpModeActive,
  .securityFlags, .dummy_count_select, .dummyClocks, .mainArrayBlock, .otpWriteAllow,
  .nvLockProgram);

/* File: sim/flash_host_model.sv */
// Host controller model issuing commands on the link clock.
// Assumes the link clock stands still between frames.
`timescale 1ns/10ps
module flash_host_model
  import flash_sec_pkg::*;
(
  // Link
  output logic linkClk,
  output logic writeSecurityCmd,
  output logic protectModeCmd,
  output logic dummyWriteCmd,
  output logic [flash_sec_pkg::DC_WIDTH-1:0] dummyWriteData
);
  // ==========
  // Frames
  initial begin
    linkClk = 0;
    {writeSecurityCmd, protectModeCmd, dummyWriteCmd} = 3'h0;
    dummyWriteData = 2'h0;
  end
  task automatic tick();
    #62.5 linkClk = 1;
    #62.5 linkClk = 0;
  endtask
  // Command held over one rising edge, data scrambled after
  task automatic send(input logic [2:0] k, input logic [1:0] d);
    tick();
    tick();
    {writeSecurityCmd, protectModeCmd, dummyWriteCmd} = k;
    dummyWriteData = d;
    tick();
    {writeSecurityCmd, protectModeCmd, dummyWriteCmd} = 3'h0;
    dummyWriteData = ~d;
    tick();
    tick();
  endtask
endmodule

/* File: sim/flash_security_status_and_dummy_config_bench.sv */
// Self-checking bench for the security flag block.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module flash_security_status_and_dummy_config_bench;
  import flash_sec_pkg::*;
  logic ref_clk = 0, rst_b = 0, clkEn = 1, otpModeActive = 0;
  logic eraseOk = 0, eraseBad = 0, programOk = 0, programBad = 0;
  logic eraseSuspended = 0, eraseResumed = 0, programSuspended = 0, programResumed = 0;
  logic nvCustLock = 0, nvProtMode = 0, factoryLockPin = 0;
  logic linkClk, writeSecurityCmd, protectModeCmd, dummyWriteCmd, mainArrayBlock;
  logic otpWriteAllow, nvLockProgram, nvProtProgram;
  logic [1:0] dummyWriteData, dummy_count_select;
  logic [7:0] securityFlags;
  logic [3:0] dummyClocks;
  int fails = 0, cmp_count = 0, nLock = 0, nProt = 0;
  // Events applied, then expected flag image of bits 6:2
  logic [15:0] rows [10] = '{16'h8040, 16'h2060, 16'h4020, 16'h1000, 16'h0808,
    16'h020C, 16'h0404, 16'h0100, 16'hC040, 16'h3060};
  logic [3:0] dcTab [4] = '{4'hA, 4'h8, 4'h6, 4'h8};
  // ==========
  // Instances
  flash_security_status_and_dummy_config i_dut (.ref_clk, .rst_b, .clkEn, .linkClk,
    .writeSecurityCmd, .protectModeCmd, .dummyWriteCmd, .dummyWriteData, .eraseOk,
    .eraseBad, .programOk, .programBad, .eraseSuspended, .eraseResumed, .programSuspended,
    .programResumed, .otpModeActive, .nvCustLock, .nvProtMode, .factoryLockPin,
    .securityFlags, .dummy_count_select, .dummyClocks, .mainArrayBlock, .otpWriteAllow,
    .nvLockProgram, .nvProtProgram);
  flash_host_model i_host (.linkClk, .writeSecurityCmd, .protectModeCmd, .dummyWriteCmd,
    .dummyWriteData);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (nvLockProgram === 1'b1) nLock++;
    if (nvProtProgram === 1'b1) nProt++;
  end
  // ==========
  // Tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic ev(input logic [7:0] v);
    {eraseBad, eraseOk, programBad, programOk} = v[7:4];
    {eraseSuspended, eraseResumed, programSuspended, programResumed} = v[3:0];
  endtask
  task automatic doReset();
    rst_b = 0;
    cyc(16);
    rst_b = 1;
    cyc(8);
  endtask
  task automatic end_sim();
    $display("fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    doReset();
    chk("flags", 8'h00, securityFlags);
    chk("dclk", 8'h0A, {4'h0, dummyClocks});
    chk("owa", 8'h01, {7'h0, otpWriteAllow});
    foreach (rows[i]) begin
      ev(rows[i][15:8]);
      cyc(1);
      ev(8'h00);
      cyc(3);
      chk("flags", rows[i][7:0], securityFlags & 8'h7C);
    end
    clkEn = 0;
    ev(8'h50);
    cyc(4);
    chk("frozen", 8'h60, securityFlags & 8'h7C);
    clkEn = 1;
    cyc(1);
    ev(8'h00);
    cyc(3);
    chk("thawed", 8'h00, securityFlags & 8'h7C);
    for (int k = 3; k >= 0; k--) begin
      i_host.send(3'h1, 2'(k));
      cyc(6);
      chk("dsel", 8'(k), {6'h0, dummy_count_select});
      chk("dclk", {4'h0, dcTab[k]}, {4'h0, dummyClocks});
    end
    factoryLockPin = 1;
    otpModeActive = 1;
    cyc(5);
    chk("fact", 8'h01, securityFlags & 8'h01);
    chk("mab", 8'h01, {7'h0, mainArrayBlock});
    otpModeActive = 0;
    i_host.send(3'h4, 2'h0);
    cyc(6);
    chk("lock", 8'h02, securityFlags & 8'h02);
    chk("owa", 8'h00, {7'h0, otpWriteAllow});
    i_host.send(3'h4, 2'h0);
    i_host.send(3'h2, 2'h0);
    cyc(6);
    chk("flags", 8'h82, securityFlags & 8'h82);
    chk("pulses", 8'h11, 8'(nLock * 16 + nProt));
    nvCustLock = 1;
    nvProtMode = 1;
    doReset();
    chk("nvload", 8'h83, securityFlags);
    end_sim();
  end
endmodule
